// ===== hdl/sdf_filter.sv
`timescale 1ns/1ps
// Summary of operation
// - each channel is filtered by a third-order sinc of length N, N being the ratio.
// - one output word is made for every N modulator samples.
// - the ratio comes from a three-bit select field.
// - eight ratios from 128 to 16384 are offered, 1024 after reset.
// - output rate is the modulator rate over N, so each power mode clock scales it.
// - a channel restarts settling on enable, on input or gain change, or on resync.
// - settling after a resync completes within the listed master clock count for each ratio.
// - after a restart the output is settled by the fourth conversion period.
// - words are produced during settling without suppression or marking.
// - settling time does not depend on any phase calibration value.
// - after reset the first results come from a first-order sinc path.
// - after two startup words the third-order path is used until the next reset.
// - the modulator and the filter input run at half the master clock.
// - a two-bit field picks high-resolution, low-power or very-low-power mode.

module sdf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	// output stage loads when empty or drained
	assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
	assign push = in_valid_in && in_ready_out;
	assign pop = (cnt_q != '0) && (!out_valid_out || out_ready_in);
	// storage
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
	// pointers and fill count
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// registered read side
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out <= mem_q[rd_q];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule

module sdf_filter #(
	parameter int unsigned SETTLE_CLK [8] = sdf_pkg::SETTLE_CLK
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [sdf_pkg::NUM_CH-1:0] mod_bits_in,
	input wire logic [sdf_pkg::NUM_CH-1:0] chan_enable_in,
	input wire logic [sdf_pkg::NUM_CH-1:0] chan_cfg_change_in,
	input wire logic resync_in,
	input wire logic [2:0] oversampling_ratio_select_in,
	input wire logic [1:0] power_mode_select_in,
	input wire logic word_ready_in,
	output logic mod_clk_out,
	output logic [2:0] oversampling_ratio_out,
	output logic [1:0] power_mode_out,
	output logic word_valid_out,
	output sdf_pkg::sdf_word_t word_out,
	output logic overrun_out
);
	localparam int unsigned NC = sdf_pkg::NUM_CH;
	localparam int unsigned AW = sdf_pkg::ACC_W;

	// last sample index of a conversion for a ratio code
	function automatic logic [sdf_pkg::PH_W-1:0] osr_last(input logic [2:0] code);
		logic [sdf_pkg::PH_W:0] n;
		n = (sdf_pkg::PH_W+1)'(1) << (sdf_pkg::OSR_LOG_BASE + 4'(code));
		return sdf_pkg::PH_W'(n - 1'b1);
	endfunction

	// align a sum to the top of the accumulator and make it signed
	function automatic logic [sdf_pkg::OUT_W-1:0] to_word(input logic [AW-1:0] v,
		input logic [5:0] sh);
		logic [AW-1:0] a;
		a = v << sh;
		return a[AW-1 -: sdf_pkg::OUT_W] - sdf_pkg::MID_SCALE;
	endfunction

	logic [NC-1:0] bits_m_q;
	logic [NC-1:0] bits_s_q;
	logic div_q;
	logic samp;
	logic [sdf_pkg::PH_W-1:0] ph_q;
	logic dec_q;
	logic [2:0] osr_q;
	logic [1:0] pwr_q;
	logic [1:0] boot_q;
	logic [NC-1:0] en_q;
	logic [NC-1:0] restart;
	logic [3:0] klog;
	logic [5:0] sh3;
	logic [5:0] sh1;
	logic fifo_rdy;
	logic pend_q;
	sdf_pkg::sdf_word_t pend_data_q;
	logic overrun_q;
	logic [NC-1:0][sdf_pkg::OUT_W-1:0] res3;
	logic [NC-1:0][sdf_pkg::OUT_W-1:0] res1;
	logic [AW-1:0] i3_0;

	// modulator bits cross in from the pins
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bits_m_q <= '0;
			bits_s_q <= '0;
		end else begin
			bits_m_q <= mod_bits_in;
			bits_s_q <= bits_m_q;
		end
	end
	// modulator clock at half the master clock
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_q <= 1'b0;
		end else begin
			div_q <= !div_q;
		end
	end
	assign samp = div_q;
	assign mod_clk_out = div_q;
	// common decimation phase; resync realigns it
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ph_q <= '0;
			dec_q <= 1'b0;
		end else if (resync_in) begin
			ph_q <= '0;
			dec_q <= 1'b0;
		end else begin
			dec_q <= samp && (ph_q == osr_last(osr_q));
			if (samp) begin
				ph_q <= (ph_q == osr_last(osr_q)) ? '0 : ph_q + 1'b1;
			end
		end
	end
	// ratio and power mode take effect at a conversion boundary
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			osr_q <= sdf_pkg::OSR_RESET;
			pwr_q <= sdf_pkg::PWR_RESET;
		end else if (dec_q || resync_in) begin
			osr_q <= oversampling_ratio_select_in;
			pwr_q <= power_mode_select_in;
		end
	end
	assign oversampling_ratio_out = osr_q;
	assign power_mode_out = pwr_q;
	// restart sources per channel
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_q <= '0;
		end else begin
			en_q <= chan_enable_in;
		end
	end
	assign restart = (chan_enable_in & ~en_q) | chan_cfg_change_in | {NC{resync_in}};

	// shift amounts for scaling both paths to full scale
	assign klog = sdf_pkg::OSR_LOG_BASE + 4'(osr_q);
	assign sh3 = sdf_pkg::ACC_TOP - 6'(3 * klog);
	assign sh1 = sdf_pkg::ACC_TOP - 6'(klog);
	// one filter per channel; no phase offset exists, so settling length is fixed
	for (genvar c = 0; c < NC; c++) begin : g_ch
		logic [AW-1:0] i1_q, i2_q, i3_q, z1_q, z2_q, z3_q;
		logic [AW-1:0] d1, d2, d3;
		logic [sdf_pkg::PH_W:0] s1_q;
		logic clr;
		assign clr = restart[c] || !chan_enable_in[c];
		// combs run once per conversion
		assign d1 = i3_q - z1_q;
		assign d2 = d1 - z2_q;
		assign d3 = d2 - z3_q;
		assign res3[c] = to_word(d3, sh3);
		assign res1[c] = to_word(AW'(s1_q), sh1);

		// integrators on every modulator sample
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				i1_q <= '0;
				i2_q <= '0;
				i3_q <= '0;
			end else if (clr) begin
				i1_q <= '0;
				i2_q <= '0;
				i3_q <= '0;
			end else if (samp) begin
				i1_q <= i1_q + AW'(bits_s_q[c]);
				i2_q <= i2_q + i1_q;
				i3_q <= i3_q + i2_q;
			end
		end

		// comb delays
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				z1_q <= '0;
				z2_q <= '0;
				z3_q <= '0;
			end else if (clr) begin
				z1_q <= '0;
				z2_q <= '0;
				z3_q <= '0;
			end else if (dec_q) begin
				z1_q <= i3_q;
				z2_q <= d1;
				z3_q <= d2;
			end
		end

		// first-order startup sum, emptied each conversion
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				s1_q <= '0;
			end else if (clr || dec_q) begin
				s1_q <= '0;
			end else if (samp) begin
				s1_q <= s1_q + (sdf_pkg::PH_W+1)'(bits_s_q[c]);
			end
		end
	end
	assign i3_0 = g_ch[0].i3_q;

	// startup word count, frozen once the third-order path is in use
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			boot_q <= '0;
		end else if (dec_q && boot_q != sdf_pkg::FAST_WORDS) begin
			boot_q <= boot_q + 1'b1;
		end
	end

	// every conversion is offered, settled or not
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_q <= 1'b0;
			pend_data_q <= '0;
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= dec_q && pend_q && !fifo_rdy;
			if (dec_q) begin
				pend_q <= 1'b1;
				pend_data_q.fast_path <= (boot_q != sdf_pkg::FAST_WORDS);
				pend_data_q.sample <= (boot_q != sdf_pkg::FAST_WORDS) ? res1 : res3;
			end else if (fifo_rdy) begin
				pend_q <= 1'b0;
			end
		end
	end
	assign overrun_out = overrun_q;

	sdf_fifo #(
		.WIDTH(sdf_pkg::WORD_W),
		.DEPTH(sdf_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(pend_q),
		.in_ready_out(fifo_rdy),
		.in_data_in(pend_data_q),
		.out_valid_out(word_valid_out),
		.out_ready_in(word_ready_in),
		.out_data_out(word_out)
	);

	// helper counters for timing checks
	logic [16:0] per_q;
	logic per_ok_q;
	logic [16:0] st_q;
	logic [1:0] nd_q;
	logic [2:0] st_osr_q;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			per_q <= '0;
			per_ok_q <= 1'b0;
			st_q <= '0;
			nd_q <= 2'h3;
			st_osr_q <= '0;
		end else begin
			per_q <= dec_q ? '0 : per_q + 1'b1;
			per_ok_q <= resync_in ? 1'b0 : (dec_q ? 1'b1 : per_ok_q);
			if (resync_in) begin
				st_q <= '0;
				nd_q <= '0;
				st_osr_q <= oversampling_ratio_select_in; // ratio loaded with the resync
			end else begin
				st_q <= (st_q == '1) ? st_q : st_q + 1'b1;
				if (dec_q && nd_q != 2'h3) begin
					nd_q <= nd_q + 1'b1;
				end
			end
		end
	end

	a_mod_half_rate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		mod_clk_out |=> !mod_clk_out ##1 mod_clk_out)
		else $error("modulator clock not half the master clock");
	a_dec_spacing: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q && per_ok_q && $stable(osr_q) |-> 32'(per_q) + 1 == (32'h0000_0100 << $past(osr_q)))
		else $error("conversion spacing differs from twice the ratio");
	a_osr_reset: assert property (@(posedge clk_sys_in)
		$rose(rst_b_in) |-> oversampling_ratio_out == 3'h3)
		else $error("ratio not 1024 after reset");
	a_osr_take: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q && !resync_in |=> osr_q == $past(oversampling_ratio_select_in))
		else $error("ratio select not taken at boundary");
	a_fast_first: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q && boot_q == 2'h0 |=> pend_data_q.fast_path)
		else $error("first word not from startup path");
	a_sinc3_stays: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		boot_q == 2'h2 |=> boot_q == 2'h2 && (!$past(dec_q) || !pend_data_q.fast_path))
		else $error("left third-order path before reset");
	a_restart_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		restart[0] |=> i3_0 == '0)
		else $error("restart did not clear the filter");
	a_settle_time: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q && nd_q == 2'h2 && osr_q == st_osr_q |-> 32'(st_q) < SETTLE_CLK[osr_q])
		else $error("third conversion after resync later than settling time");
	a_no_gating: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q |=> pend_q)
		else $error("conversion word suppressed");
	a_word_order: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out))
		else $error("word changed while stalled");
	c_resync_settle: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q && nd_q == 2'h2);
	c_fast_to_sinc3: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		$changed(boot_q) && boot_q == 2'h2);
	c_overrun: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) overrun_out);
	c_osr_change: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		dec_q ##1 $changed(osr_q));
endmodule

// ===== hdl/sdf_pkg.sv
package sdf_pkg;
	// channel and datapath widths
	localparam int unsigned NUM_CH = 6;
	localparam int unsigned ACC_W = 43;
	localparam int unsigned OUT_W = 24;
	localparam int unsigned PH_W = 14;
	localparam int unsigned FIFO_DEPTH = 8;
	// ratio select field: code 0 is 128, code 7 is 16384
	localparam logic [2:0] OSR_RESET = 3'h3;
	localparam logic [3:0] OSR_LOG_BASE = 4'h7;
	// output scaling: top bit and midscale offset
	localparam logic [5:0] ACC_TOP = 6'h2a;
	localparam logic [OUT_W-1:0] MID_SCALE = 24'h40_0000;
	// words produced by the first-order path after reset
	localparam logic [1:0] FAST_WORDS = 2'h2;
	// settling time per ratio code, in master clock periods
	localparam int unsigned SETTLE_CLK [8] = '{860, 1628, 3164, 6236, 12380, 24668, 49244,
		98396};
	// nominal master clocks per power mode, in kHz
	localparam int unsigned MCLK_HR_KHZ = 8192;
	localparam int unsigned MCLK_LP_KHZ = 4096;
	localparam int unsigned MCLK_VLP_KHZ = 2048;
	// power mode codes
	typedef enum logic [1:0] {
		SDF_VLP = 2'h0,
		SDF_LP = 2'h1,
		SDF_HR = 2'h2
	} sdf_pwr_t;
	localparam logic [1:0] PWR_RESET = 2'h2;
	// one conversion: every channel plus the startup path marker
	typedef struct packed {
		logic fast_path;
		logic [NUM_CH-1:0][OUT_W-1:0] sample;
	} sdf_word_t;
	localparam int unsigned WORD_W = $bits(sdf_word_t);
endpackage

// ===== dv/sdf_mod_model.sv
`timescale 1ns/1ps
// behavioural modulator: first-order noise shaper, one bit per channel per modulator clock
module sdf_mod_model (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic mod_clk_in,
	input wire logic [sdf_pkg::NUM_CH-1:0][8:0] density_in,
	output logic [sdf_pkg::NUM_CH-1:0] mod_bits_out
);
	logic [sdf_pkg::NUM_CH-1:0][7:0] acc_q;
	// steps once per modulator period, so the bit pattern is periodic in the density
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mod_bits_out <= '0;
			acc_q <= '0;
		end else if (mod_clk_in) begin
			for (int i = 0; i < sdf_pkg::NUM_CH; i++) begin
				{mod_bits_out[i], acc_q[i]} <= acc_q[i] + density_in[i];
			end
		end
	end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_in;
	logic rst_b_in;
	logic [5:0] mod_bits;
	logic [5:0] chan_en;
	logic [5:0] cfg_chg;
	logic resync;
	logic [2:0] osr_sel;
	logic [1:0] pwr_sel;
	logic ready;
	logic mod_clk;
	logic [2:0] oversampling_ratio;
	logic [1:0] pwr;
	logic valid;
	logic overrun;
	logic [5:0][8:0] dens;
	sdf_pkg::sdf_word_t word;
	sdf_pkg::sdf_word_t w;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int t;
	int t0;
	int ovr;
	int drained;
	logic m0;

	sdf_filter sdf_filter_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .mod_bits_in(mod_bits),
		.chan_enable_in(chan_en), .chan_cfg_change_in(cfg_chg), .resync_in(resync),
		.oversampling_ratio_select_in(osr_sel), .power_mode_select_in(pwr_sel),
		.word_ready_in(ready), .mod_clk_out(mod_clk), .oversampling_ratio_out(oversampling_ratio),
		.power_mode_out(pwr), .word_valid_out(valid), .word_out(word), .overrun_out(overrun));
	sdf_mod_model sdf_mod_model_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.mod_clk_in(mod_clk), .density_in(dens), .mod_bits_out(mod_bits));

	// master clock, 4 ns period
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// cycle count and hang limit
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	// waits for one accepted word, keeps it and its cycle
	task automatic get_word();
		int k;
		k = 0;
		do begin
			@(negedge clk_sys_in);
			k++;
		end while (!(valid === 1'b1 && ready === 1'b1) && k < 40000);
		if (k >= 40000)
			fail_count++;
		w = word;
		t = cyc;
		step(1);
	endtask

	task automatic do_resync(input logic [2:0] c, input logic [1:0] p);
		osr_sel = c;
		pwr_sel = p;
		resync = 1'b1;
		step(1);
		resync = 1'b0;
		step(1);
		chk("ratio code", oversampling_ratio, c);
		chk("power code", pwr, p);
	endtask

	// settled value of a periodic density pattern, disabled channels sit at zero density
	function automatic logic [23:0] exp_s(input logic [8:0] d, input logic en);
		return en ? 24'((int'(d) - 128) * 32768) : 24'hc0_0000;
	endfunction

	task automatic chk_all();
		for (int i = 0; i < 6; i++)
			chk("sample", w.sample[i], exp_s(dens[i], chan_en[i]));
	endtask

	task automatic settle(input int n);
		repeat (n) get_word();
		chk_all();
	endtask

	initial begin
		rst_b_in = 1'b0;
		resync = 1'b0;
		cfg_chg = '0;
		chan_en = '1;
		osr_sel = 3'h3;
		pwr_sel = 2'h2;
		ready = 1'b1;
		void'($urandom(40));
		for (int i = 0; i < 6; i++)
			dens[i] = 9'(2 * $urandom_range(0, 128));
		step(4);
		chk("reset ratio", oversampling_ratio, 3'h3);
		chk("reset power", pwr, 2'h2);
		rst_b_in = 1'b1;
		@(negedge clk_sys_in);
		m0 = mod_clk;
		@(negedge clk_sys_in);
		chk("mod clock toggles", mod_clk, !m0);
		get_word();
		chk("startup path", w.fast_path, 1);
		t0 = t;
		get_word();
		chk("startup path", w.fast_path, 1);
		chk("word period", t - t0, 2048);
		get_word();
		chk("third order path", w.fast_path, 0);
		$display("test startup done");
		for (int c = 0; c < 8; c++) begin
			do_resync(3'(c), 2'(c % 3));
			if (c < 5) begin
				get_word();
				t0 = t;
				get_word();
				chk("word period", t - t0, 256 << c);
				chk("stays third order", w.fast_path, 0);
			end
		end
		$display("test ratio codes done");
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 6; i++)
				dens[i] = 9'(2 * $urandom_range(0, 128));
			if (r == 0) begin
				dens[0] = 9'h000;
				dens[1] = 9'h100;
			end
			do_resync(3'h0, 2'h2);
			settle(4);
		end
		$display("test settled values done");
		for (int k = 0; k < 2; k++) begin
			dens[k + 3] = 9'(2 * $urandom_range(0, 128));
			step(100);
			cfg_chg[k + 3] = 1'b1;
			step(1);
			cfg_chg = '0;
			settle(4);
		end
		chan_en[2] = 1'b0;
		settle(2);
		chan_en[2] = 1'b1;
		settle(4);
		$display("test channel restart done");
		ready = 1'b0;
		ovr = 0;
		repeat (3000) begin
			@(negedge clk_sys_in);
			if (overrun === 1'b1)
				ovr++;
		end
		chk("valid held", valid, 1);
		step(1);
		ready = 1'b1;
		drained = 0;
		repeat (40) begin
			@(negedge clk_sys_in);
			if (valid === 1'b1)
				drained++;
		end
		chk("overrun seen", ovr > 0, 1);
		chk("fifo drained", drained >= sdf_pkg::FIFO_DEPTH, 1);
		$display("test buffer done");
		wrap_up();
	end
endmodule
